// ==== common/analog_out_pkg.sv ====
// constants shared by the two-channel analog output controller
package analog_out_pkg;
  localparam int NUM_CH    = 2;
  localparam int DAC_W     = 12;
  localparam int WORD_W    = 16;
  localparam int CTRL_W    = 8;
  localparam int REG_COUNT = 64;
  localparam int REG_IDX_W = 6;
  // register indices inside one channel's set
  localparam logic [5:0] REG_RAW_VALUE    = 6'h05;
  localparam logic [5:0] REG_DIAG_INFO    = 6'h06;
  localparam logic [5:0] REG_FUNC_CALL    = 6'h07;
  localparam logic [5:0] REG_TYPE_ID      = 6'h08;
  localparam logic [5:0] REG_FW_TEXT      = 6'h09;
  localparam logic [5:0] REG_SHIFT_CHAIN  = 6'h0a;
  localparam logic [5:0] REG_CHAN_COUNT   = 6'h0b;
  localparam logic [5:0] REG_MIN_LEN      = 6'h0c;
  localparam logic [5:0] REG_DATA_KIND    = 6'h0d;
  localparam logic [5:0] REG_MFR_OFFSET   = 6'h13;
  localparam logic [5:0] REG_MFR_GAIN     = 6'h14;
  localparam logic [5:0] REG_MFR_FALLBACK = 6'h15;
  localparam logic [5:0] REG_FEATURE      = 6'h20;
  localparam logic [5:0] REG_USR_OFFSET   = 6'h21;
  localparam logic [5:0] REG_USR_GAIN     = 6'h22;
  localparam logic [5:0] REG_USR_FALLBACK = 6'h23;
  // address ranges
  localparam logic [5:0] RANGE_WORK_HI = 6'h07;
  localparam logic [5:0] RANGE_TYPE_HI = 6'h0f;
  // reset values
  localparam logic [15:0] MFR_OFFSET_RST   = 16'h0000;
  localparam logic [15:0] MFR_GAIN_RST     = 16'h0020;
  localparam logic [15:0] MFR_FALLBACK_RST = 16'h0000;
  localparam logic [15:0] FEATURE_RST      = 16'h0006;
  localparam logic [15:0] USR_OFFSET_RST   = 16'h0000;
  localparam logic [15:0] USR_GAIN_RST     = 16'h0100;
  localparam logic [15:0] USR_FALLBACK_RST = 16'h0000;
  // feature_enable_word bits
  localparam int FEAT_USR_SCALE    = 0;
  localparam int FEAT_MFR_SCALE    = 1;
  localparam int FEAT_WATCHDOG     = 2;
  localparam int FEAT_USR_FALLBACK = 8;
  // control byte fields
  localparam int CTRL_REG_MODE = 7;
  localparam int CTRL_WRITE    = 6;
  // data_layout_kind codes
  localparam logic [15:0] KIND_NONE        = 16'h0000;
  localparam logic [15:0] KIND_BYTE_ARRAY  = 16'h0001;
  localparam logic [15:0] KIND_BYTE_STRUCT = 16'h0002;
  // gain fraction bits and converter ceiling
  localparam int SCALE_FRAC = 8;
  localparam logic [11:0] DAC_MAX = 12'hfff;
  // watchdog timing
  localparam int unsigned CLK_HZ     = 250_000_000;
  localparam int unsigned WD_TIME_MS = 100;
  localparam int unsigned WD_CYCLES  = CLK_HZ / 1000 * WD_TIME_MS;
  localparam int WD_CNT_W = 25;
  // input buffer
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_W     = 1 + CTRL_W + WORD_W;
  // identity defaults, values arbitrary
  localparam logic [15:0] TYPE_ID_DEFAULT     = 16'h0a5c;
  localparam logic [15:0] FW_TEXT_DEFAULT     = 16'h3141;
  localparam logic [15:0] SHIFT_CHAIN_DEFAULT = 16'h0118;
  localparam logic [15:0] CHAN_COUNT_DEFAULT  = 16'h0002;
  localparam logic [15:0] MIN_LEN_DEFAULT     = 16'h0018;
endpackage

// ==== design/analog_out_ctrl.sv ====
// two-channel analog output controller: process image, registers, scaling, watchdog
// Notes on behaviour
// - each channel drives a 12-bit unsigned converter code
// - input word is twos complement, 0x7fff full scale
// - image carries 16-bit word plus control byte
// - no data for 100 ms forces fallback output
// - alive indicator off after channel watchdog overflow
// - no scaling: raw value equals process word
// - maker scaling: offset plus gain times word
// - user scaling: offset plus gain times word
// - both: maker line first, then user line
// - each channel owns 64 word registers
// - register ranges split by address
// - registers 0-7 are volatile working storage
// - register 6 holds diagnostic flags
// - register 7 takes function, echoes its number
// - registers 8-15 read only, writes ignored
// - register 8 returns module type code
// - register 9 returns firmware version text
// - register 10 reports shift chain layout
// - register 11 reports logical channel count
// - register 12 msb set omits status byte
// - register 13 encodes data layout kind
// - status byte sits low at channel base
// - feature word enables scaling, watchdog, fallback
// - control byte: mode, write flag, index
// - after reset or overflow apply fallback
`timescale 1ns/10ps
`default_nettype none
module analog_out_ctrl #(
  parameter int unsigned  WD_LIMIT    = analog_out_pkg::WD_CYCLES,
  parameter logic [15:0]  TYPE_ID     = analog_out_pkg::TYPE_ID_DEFAULT,
  parameter logic [15:0]  FW_TEXT     = analog_out_pkg::FW_TEXT_DEFAULT,
  parameter logic [15:0]  SHIFT_CHAIN = analog_out_pkg::SHIFT_CHAIN_DEFAULT,
  parameter logic [15:0]  CHAN_COUNT  = analog_out_pkg::CHAN_COUNT_DEFAULT,
  parameter logic [15:0]  MIN_LEN     = analog_out_pkg::MIN_LEN_DEFAULT
) (
  input  wire logic                                  i_clk,
  input  wire logic                                  i_sys_rst,
  input  wire logic                                  i_ce,
  input  wire logic                                  i_img_valid,
  output logic                                       o_img_ready,
  input  wire logic                                  i_img_chan,
  input  wire logic [analog_out_pkg::CTRL_W-1:0]     i_img_ctrl,
  input  wire logic [analog_out_pkg::WORD_W-1:0]     i_img_word,
  output logic                                       o_reply_valid,
  input  wire logic                                  i_reply_ready,
  output logic                                       o_reply_chan,
  output logic [analog_out_pkg::CTRL_W-1:0]          o_img_status,
  output logic [analog_out_pkg::WORD_W-1:0]          o_img_word,
  output logic                                       o_status_present,
  output logic [analog_out_pkg::NUM_CH-1:0][11:0]    o_dac_code,
  output logic [analog_out_pkg::NUM_CH-1:0]          o_channel_alive_indicator
);
  import analog_out_pkg::*;

  typedef struct packed {
    logic [NUM_CH-1:0][REG_COUNT-1:0][WORD_W-1:0] regs;
    logic [NUM_CH-1:0][WORD_W-1:0]                proc_word;
    logic [NUM_CH-1:0][WD_CNT_W-1:0]              wd_cnt;
    logic [NUM_CH-1:0]                            wd_over;
    logic [NUM_CH-1:0]                            live;
    logic [NUM_CH-1:0][DAC_W-1:0]                 dac;
    logic                                         reply_valid;
    logic                                         reply_chan;
    logic [CTRL_W-1:0]                            reply_status;
    logic [WORD_W-1:0]                            reply_word;
  } ctrl_state_t;

  ctrl_state_t                st_reg;
  ctrl_state_t                st_next;
  logic                       fifo_valid;
  logic                       fifo_ready;
  logic [FIFO_W-1:0]          fifo_data;
  logic                       pop;
  logic                       pop_chan;
  logic [CTRL_W-1:0]          pop_ctrl;
  logic [WORD_W-1:0]          pop_word;
  logic [REG_IDX_W-1:0]       register_index_field;
  logic                       write_not_read_flag;
  logic [NUM_CH-1:0][DAC_W-1:0] scaled_code;
  logic [NUM_CH-1:0][DAC_W-1:0] fallback_code;

  // clamp a signed result into the converter span
  function automatic logic [DAC_W-1:0] clamp_dac(input logic signed [15:0] v);
    if (v < 0) begin
      return '0;
    end else if (v > 16'sh0fff) begin
      return DAC_MAX;
    end else begin
      return v[DAC_W-1:0];
    end
  endfunction

  // register read mux; type registers are constants
  function automatic logic [WORD_W-1:0] reg_read(input ctrl_state_t s, input logic c,
                                                 input logic [REG_IDX_W-1:0] idx);
    unique case (idx)
      REG_FUNC_CALL:   return {8'h00, s.regs[c][REG_FUNC_CALL][7:0]};
      REG_TYPE_ID:     return TYPE_ID;
      REG_FW_TEXT:     return FW_TEXT;
      REG_SHIFT_CHAIN: return SHIFT_CHAIN;
      REG_CHAN_COUNT:  return CHAN_COUNT;
      REG_MIN_LEN:     return MIN_LEN;
      REG_DATA_KIND:   return KIND_BYTE_STRUCT;
      default: begin
        if (idx > REG_DATA_KIND && idx <= RANGE_TYPE_HI) begin
          return '0;
        end else begin
          return s.regs[c][idx];
        end
      end
    endcase
  endfunction

  // control register reset image
  function automatic ctrl_state_t reset_state();
    ctrl_state_t s;
    s = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      s.regs[c][REG_MFR_OFFSET]   = MFR_OFFSET_RST;
      s.regs[c][REG_MFR_GAIN]     = MFR_GAIN_RST;
      s.regs[c][REG_MFR_FALLBACK] = MFR_FALLBACK_RST;
      s.regs[c][REG_FEATURE]      = FEATURE_RST;
      s.regs[c][REG_USR_OFFSET]   = USR_OFFSET_RST;
      s.regs[c][REG_USR_GAIN]     = USR_GAIN_RST;
      s.regs[c][REG_USR_FALLBACK] = USR_FALLBACK_RST;
    end
    return s;
  endfunction

  // incoming image words queue up here
  sample_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_in_fifo (
    .i_clk      (i_clk),
    .i_sys_rst  (i_sys_rst),
    .i_ce       (i_ce),
    .i_wr_valid (i_img_valid),
    .o_wr_ready (o_img_ready),
    .i_wr_data  ({i_img_chan, i_img_ctrl, i_img_word}),
    .o_rd_valid (fifo_valid),
    .i_rd_ready (fifo_ready),
    .o_rd_data  (fifo_data)
  );

  // drain stalls while an unread reply is held
  assign fifo_ready           = i_ce && (!st_reg.reply_valid || i_reply_ready);
  assign pop                  = fifo_valid && fifo_ready;
  assign {pop_chan, pop_ctrl, pop_word} = fifo_data;
  assign register_index_field = pop_ctrl[REG_IDX_W-1:0];
  assign write_not_read_flag  = pop_ctrl[CTRL_WRITE];

  // per channel: maker line then user line, then clamp
  generate
    for (genvar g = 0; g < NUM_CH; g++) begin : g_chan
      logic signed [15:0] x_word;
      logic signed [15:0] mfr_y;
      logic signed [15:0] usr_in;
      logic signed [15:0] usr_y;
      logic signed [15:0] final_y;
      logic [WORD_W-1:0]  feat;
      assign feat   = st_reg.regs[g][REG_FEATURE];
      assign x_word = signed'(st_reg.proc_word[g]);
      line_scaler #(
        .GAIN_SIGNED (1'b0)
      ) u_mfr (
        .i_x      (x_word),
        .i_gain   (st_reg.regs[g][REG_MFR_GAIN]),
        .i_offset (st_reg.regs[g][REG_MFR_OFFSET]),
        .o_y      (mfr_y)
      );
      line_scaler #(
        .GAIN_SIGNED (1'b1)
      ) u_usr (
        .i_x      (usr_in),
        .i_gain   (st_reg.regs[g][REG_USR_GAIN]),
        .i_offset (st_reg.regs[g][REG_USR_OFFSET]),
        .o_y      (usr_y)
      );
      assign usr_in  = feat[FEAT_MFR_SCALE] ? mfr_y : x_word;
      assign final_y = feat[FEAT_USR_SCALE] ? usr_y : usr_in;
      assign scaled_code[g] = clamp_dac(final_y);
      assign fallback_code[g] = feat[FEAT_USR_FALLBACK] ?
          clamp_dac(signed'(st_reg.regs[g][REG_USR_FALLBACK])) :
          st_reg.regs[g][REG_MFR_FALLBACK][DAC_W-1:0];
    end
  endgenerate

  // next-state logic for watchdog, output codes, registers and replies
  always_comb begin
    st_next = st_reg;
    if (st_reg.reply_valid && i_reply_ready) begin
      st_next.reply_valid = 1'b0;
    end
    for (int c = 0; c < NUM_CH; c++) begin
      if (pop && !pop_ctrl[CTRL_REG_MODE] && (pop_chan == 1'(c))) begin
        st_next.proc_word[c] = pop_word;
        st_next.live[c]      = 1'b1;
        st_next.wd_cnt[c]    = '0;
        st_next.wd_over[c]   = 1'b0;
      end else if (!st_reg.regs[c][REG_FEATURE][FEAT_WATCHDOG]) begin
        st_next.wd_cnt[c]  = '0;
        st_next.wd_over[c] = 1'b0;
      end else if (st_reg.wd_cnt[c] >= WD_CNT_W'(WD_LIMIT - 1)) begin
        st_next.wd_over[c] = 1'b1;
        st_next.live[c]    = 1'b0;
      end else begin
        st_next.wd_cnt[c] = st_reg.wd_cnt[c] + 1'b1;
      end
      st_next.dac[c] = (st_reg.live[c] && !st_reg.wd_over[c]) ?
                       scaled_code[c] : fallback_code[c];
    end
    // register mode access on the popped channel
    if (pop) begin
      st_next.reply_valid  = 1'b1;
      st_next.reply_chan   = pop_chan;
      st_next.reply_status = pop_ctrl;
      st_next.reply_word   = '0;
      if (pop_ctrl[CTRL_REG_MODE]) begin
        if (!write_not_read_flag) begin
          st_next.reply_word = reg_read(st_reg, pop_chan, register_index_field);
        end else if (register_index_field == REG_FUNC_CALL) begin
          st_next.regs[pop_chan][REG_FUNC_CALL] = {8'h00, pop_word[7:0]};
        end else if (register_index_field < REG_RAW_VALUE ||
                     register_index_field > RANGE_TYPE_HI) begin
          st_next.regs[pop_chan][register_index_field] = pop_word;
        end
      end
    end
    // working registers mirror live state
    for (int c = 0; c < NUM_CH; c++) begin
      st_next.regs[c][REG_RAW_VALUE] = {4'h0, st_next.dac[c]};
      st_next.regs[c][REG_DIAG_INFO] = {15'h0000, st_next.wd_over[c]};
    end
    if (!i_ce) begin
      st_next = st_reg;
    end
    if (i_sys_rst) begin
      st_next = reset_state();
    end
  end

  always_ff @(posedge i_clk) begin
    st_reg <= st_next;
  end

  // outputs
  assign o_reply_valid             = st_reg.reply_valid;
  assign o_reply_chan              = st_reg.reply_chan;
  assign o_img_status              = st_reg.reply_status;
  assign o_img_word                = st_reg.reply_word;
  assign o_status_present          = !MIN_LEN[15];
  assign o_dac_code                = st_reg.dac;
  assign o_channel_alive_indicator = ~st_reg.wd_over;

  // checks
  a_reply_after_pop:
  assert property (@(posedge i_clk) disable iff (i_sys_rst)
    pop |=> o_reply_valid && (o_reply_chan == $past(pop_chan)))
    else $error("no reply after popped image word");

  a_write_ack_echo:
  assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (pop && pop_ctrl[CTRL_REG_MODE] && pop_ctrl[CTRL_WRITE]) |=>
      (o_img_status == $past(pop_ctrl)) && (o_img_word == 16'h0000))
    else $error("write acknowledge does not echo control byte");

  a_type_read_id:
  assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (pop && pop_ctrl == 8'h88) |=> o_img_word == TYPE_ID)
    else $error("type register read returns wrong value");

  a_kind_read:
  assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (pop && pop_ctrl == 8'h8d) |=> o_img_word == KIND_BYTE_STRUCT)
    else $error("data kind register read wrong");

  a_type_write_ignored:
  assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (pop && write_not_read_flag && pop_ctrl[CTRL_REG_MODE] && register_index_field[5:3] == 3'b001)
      |=> $stable(st_reg.regs[0][15:8]) && $stable(st_reg.regs[1][15:8]))
    else $error("type register changed by a write");

  a_fallback_on_over:
  assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_ce && st_reg.wd_over[0]) |=> o_dac_code[0] == $past(fallback_code[0]))
    else $error("overflowed channel not at fallback");

  a_alive_drops:
  assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_ce && st_reg.regs[0][REG_FEATURE][FEAT_WATCHDOG] && !(pop && !pop_chan)
      && st_reg.wd_cnt[0] >= WD_CNT_W'(WD_LIMIT - 1)) |=> !o_channel_alive_indicator[0])
    else $error("alive indicator stays on after overflow");

  a_fresh_data_restarts:
  assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (pop && !pop_ctrl[CTRL_REG_MODE] && !pop_chan) |=>
      o_channel_alive_indicator[0] ##1 (o_dac_code[0] == $past(scaled_code[0]) || !$past(i_ce)))
    else $error("fresh data does not restart channel");

  a_passthru_code:
  assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_ce && st_reg.live[0] && !st_reg.wd_over[0] &&
      st_reg.regs[0][REG_FEATURE][1:0] == 2'b00) |=>
      o_dac_code[0] == $past(clamp_dac(signed'(st_reg.proc_word[0]))))
    else $error("unscaled code differs from process word");

  a_frozen_hold:
  assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !i_ce |=> $stable(o_dac_code) && $stable(o_reply_valid))
    else $error("state moved while clock enable low");

  a_raw_read_code:
  assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (pop && pop_ctrl == 8'h85) |=> o_img_word == {4'h0, $past(o_dac_code[pop_chan])})
    else $error("raw value read differs from converter code");

  a_user_fallback:
  assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_ce && !st_reg.live[1] && st_reg.regs[1][REG_FEATURE][FEAT_USR_FALLBACK] &&
      st_reg.regs[1][REG_USR_FALLBACK] <= 16'h0fff) |=>
      o_dac_code[1] == $past(st_reg.regs[1][REG_USR_FALLBACK][DAC_W-1:0]))
    else $error("user fallback not applied");

  a_start_fallback:
  assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_ce && !st_reg.live[0]) |=> o_dac_code[0] == $past(fallback_code[0]))
    else $error("channel without data not at fallback");

  a_reply_holds:
  assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (o_reply_valid && !i_reply_ready) |=> o_reply_valid && $stable(o_img_status))
    else $error("reply dropped before it was taken");

  a_wd_off_clear:
  assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_ce && !st_reg.regs[0][REG_FEATURE][FEAT_WATCHDOG]) |=> o_channel_alive_indicator[0])
    else $error("overflow with watchdog disabled");
endmodule
`default_nettype wire

// ==== design/line_scaler.sv ====
// straight-line scaling stage: offset plus gain times input, saturated
`timescale 1ns/10ps
`default_nettype none
module line_scaler
  import analog_out_pkg::*;
#(
  parameter bit GAIN_SIGNED = 1'b1
) (
  input  wire logic signed [15:0] i_x,
  input  wire logic [15:0]        i_gain,
  input  wire logic [15:0]        i_offset,
  output logic signed [15:0]      o_y
);
  logic signed [16:0] gain_ext;
  logic signed [33:0] prod;
  logic signed [33:0] sum;

  // gain is q8.8, unsigned for the maker stage
  assign gain_ext = GAIN_SIGNED ? {i_gain[15], i_gain} : {1'b0, i_gain};
  assign prod     = 34'(i_x) * 34'(gain_ext);
  assign sum      = (prod >>> SCALE_FRAC) + 34'(signed'(i_offset));

  // saturate instead of wrapping
  always_comb begin
    if (sum > 34'sd32767) begin
      o_y = 16'sh7fff;
    end else if (sum < -34'sd32768) begin
      o_y = -16'sh8000;
    end else begin
      o_y = sum[15:0];
    end
  end
endmodule
`default_nettype wire

// ==== design/sample_fifo.sv ====
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_sys_rst,
  input  wire logic             i_ce,
  input  wire logic             i_wr_valid,
  output logic                  o_wr_ready,
  input  wire logic [WIDTH-1:0] i_wr_data,
  output logic                  o_rd_valid,
  input  wire logic             i_rd_ready,
  output logic [WIDTH-1:0]      o_rd_data
);
  localparam int PTR_W = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0]            wptr;
    logic [PTR_W-1:0]            rptr;
    logic [PTR_W:0]              count;
  } fifo_state_t;
  fifo_state_t st_reg;
  fifo_state_t st_next;
  logic        push;
  logic        pop;

  // handshakes, frozen while clock enable is low
  assign o_wr_ready = i_ce && (st_reg.count != (PTR_W+1)'(DEPTH));
  assign o_rd_valid = (st_reg.count != '0);
  assign o_rd_data  = st_reg.mem[st_reg.rptr];
  assign push       = i_wr_valid && o_wr_ready;
  assign pop        = o_rd_valid && i_rd_ready && i_ce;

  // pointer and occupancy update
  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wptr] = i_wr_data;
      st_next.wptr = st_reg.wptr + 1'b1;
    end
    if (pop) begin
      st_next.rptr = st_reg.rptr + 1'b1;
    end
    if (push && !pop) begin
      st_next.count = st_reg.count + 1'b1;
    end else if (pop && !push) begin
      st_next.count = st_reg.count - 1'b1;
    end
    if (i_sys_rst) begin
      st_next = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    st_reg <= st_next;
  end
endmodule
`default_nettype wire

// ==== verification/analog_out_ctrl_bench.sv ====
// self-checking bench for the two-channel analog output controller
`timescale 1ns/10ps
`default_nettype none
module analog_out_ctrl_bench;
  import analog_out_pkg::*;
  localparam int unsigned WD = 200;
  logic             clk = 1'b0;
  logic             rst = 1'b1;
  logic             ce = 1'b1;
  wire logic        valid, ready, chan, rvalid, rready, rchan, present;
  wire logic [7:0]  ctrl, status;
  wire logic [15:0] word, rword;
  wire logic [1:0][11:0] dac;
  wire logic [1:0]  alive;
  int err_count = 0;
  int tests_run = 0;

  // clock 250 MHz
  always #2 clk = ~clk;

  analog_out_ctrl #(.WD_LIMIT(WD)) dut (.i_clk(clk), .i_sys_rst(rst), .i_ce(ce),
    .i_img_valid(valid), .o_img_ready(ready), .i_img_chan(chan), .i_img_ctrl(ctrl),
    .i_img_word(word), .o_reply_valid(rvalid), .i_reply_ready(rready),
    .o_reply_chan(rchan), .o_img_status(status), .o_img_word(rword),
    .o_status_present(present), .o_dac_code(dac), .o_channel_alive_indicator(alive));

  coupler_model cm (.i_clk(clk), .i_img_ready(ready), .i_reply_valid(rvalid),
    .i_img_status(status), .i_img_word(rword), .o_img_valid(valid), .o_img_chan(chan),
    .o_img_ctrl(ctrl), .o_img_word(word), .o_reply_ready(rready));

  // compare and count
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // request helpers: register access and process word
  task automatic acc(input logic ch, input logic [7:0] c, input logic [15:0] w,
                     output logic [15:0] rw);
    logic [7:0] st;
    cm.xfer(ch, c, w, st, rw);
    check({8'h00, st}, {8'h00, c}, "status echo");
    check({15'h0, rchan}, {15'h0, ch}, "reply channel");
  endtask
  task automatic wr(input logic ch, input logic [5:0] idx, input logic [15:0] w);
    logic [15:0] rw;
    acc(ch, {2'b11, idx}, w, rw);
  endtask
  task automatic rd(input logic ch, input logic [5:0] idx, input logic [15:0] exp);
    logic [15:0] rw;
    acc(ch, {2'b10, idx}, 16'h0000, rw);
    check(rw, exp, "register read");
  endtask
  task automatic pw(input logic ch, input logic [15:0] x, input logic [11:0] exp);
    logic [15:0] rw;
    acc(ch, 8'h00, x, rw);
    repeat (2) @(posedge clk);
    check({4'h0, dac[ch]}, {4'h0, exp}, "converter code");
  endtask

  // reset values and type registers
  task automatic t_reset();
    check({14'h0, alive}, 16'h0003, "alive after reset");
    check({4'h0, dac[0]}, 16'h0000, "fallback after reset");
    rd(0, REG_FEATURE, FEATURE_RST);
    rd(1, REG_MFR_GAIN, MFR_GAIN_RST);
    rd(1, REG_USR_GAIN, USR_GAIN_RST);
    rd(0, REG_TYPE_ID, TYPE_ID_DEFAULT);
    rd(0, REG_FW_TEXT, FW_TEXT_DEFAULT);
    rd(1, REG_SHIFT_CHAIN, SHIFT_CHAIN_DEFAULT);
    rd(1, REG_CHAN_COUNT, CHAN_COUNT_DEFAULT);
    rd(0, REG_MIN_LEN, MIN_LEN_DEFAULT);
    check({15'h0, present}, {15'h0, ~MIN_LEN_DEFAULT[15]}, "status present");
    rd(0, REG_DATA_KIND, KIND_BYTE_STRUCT);
    $display("test reset done");
  endtask

  // read-only writes, command word, separate register sets
  task automatic t_regs();
    pw(0, 16'h0000, 12'h000);
    wr(0, REG_TYPE_ID, 16'hffff);
    rd(0, REG_TYPE_ID, TYPE_ID_DEFAULT);
    wr(1, REG_DATA_KIND, 16'h0000);
    rd(1, REG_DATA_KIND, KIND_BYTE_STRUCT);
    wr(0, REG_FUNC_CALL, 16'h5a03);
    rd(0, REG_FUNC_CALL, 16'h0003);
    wr(0, 6'h3f, 16'hbeef);
    wr(1, 6'h3f, 16'h1234);
    rd(0, 6'h3f, 16'hbeef);
    rd(1, 6'h3f, 16'h1234);
    $display("test registers done");
  endtask

  // the four scaling modes and the clamp
  task automatic t_scale();
    wr(0, REG_FEATURE, 16'h0004);
    pw(0, 16'h0123, 12'h123);
    pw(0, 16'h7fff, 12'hfff);
    pw(0, 16'hffff, 12'h000);
    wr(0, REG_FEATURE, 16'h0006);
    pw(0, 16'h3ff8, 12'h7ff);
    wr(0, REG_MFR_OFFSET, 16'h0008);
    pw(0, 16'h0800, 12'h108);
    wr(0, REG_USR_OFFSET, 16'h0010);
    wr(0, REG_USR_GAIN, 16'h0200);
    wr(0, REG_FEATURE, 16'h0005);
    pw(0, 16'h0100, 12'h210);
    wr(0, REG_FEATURE, 16'h0007);
    pw(0, 16'h0800, 12'h220);
    rd(0, REG_RAW_VALUE, 16'h0220);
    pw(1, 16'h0800, 12'h100);
    $display("test scaling done");
  endtask

  // overflow, both fallback sources, recovery, watchdog off
  task automatic t_wd();
    wr(0, REG_MFR_FALLBACK, 16'h0123);
    wr(1, REG_USR_FALLBACK, 16'h0456);
    wr(1, REG_FEATURE, 16'h0106);
    pw(0, 16'h0800, 12'h220);
    pw(1, 16'h0800, 12'h100);
    repeat (WD + 20) @(posedge clk);
    check({14'h0, alive}, 16'h0000, "alive after overflow");
    check({4'h0, dac[0]}, 16'h0123, "maker fallback");
    check({4'h0, dac[1]}, 16'h0456, "user fallback");
    rd(0, REG_DIAG_INFO, 16'h0001);
    wr(0, REG_FEATURE, 16'h0003);
    pw(0, 16'h0800, 12'h220);
    check({14'h0, alive}, 16'h0001, "alive after new data");
    repeat (WD + 20) @(posedge clk);
    check({14'h0, alive}, 16'h0001, "watchdog disabled");
    $display("test watchdog done");
  endtask

  // fill the buffer while replies stall, then drain in order
  task automatic t_fifo();
    logic [7:0]  st;
    logic [15:0] w;
    for (int i = 0; i < 9; i++) begin
      cm.put(1'b0, 8'h88 + 8'(i), 16'h0000);
      @(posedge clk);
    end
    check({15'h0, ready}, 16'h0000, "full buffer refuses");
    cm.slow = 2;
    for (int i = 0; i < 9; i++) begin
      cm.get(st, w);
      check({8'h00, st}, 16'h0088 + 16'(i), "reply order");
    end
    @(posedge clk);
    #1;
    check({14'h0, ready, rvalid}, 16'h0002, "buffer empty");
    $display("test buffer done");
  endtask

  // clock enable low freezes buffer and watchdog
  task automatic t_ce();
    wr(0, REG_FEATURE, 16'h0007);
    pw(0, 16'h0100, 12'h060);
    ce <= 1'b0;
    repeat (WD + 20) @(posedge clk);
    check({15'h0, ready}, 16'h0000, "frozen buffer refuses");
    check({14'h0, alive}, 16'h0001, "frozen watchdog");
    ce <= 1'b1;
    repeat (WD + 20) @(posedge clk);
    check({4'h0, dac[0]}, 16'h0123, "fallback after thaw");
    $display("test clock enable done");
  endtask

  // verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_regs();
    t_scale();
    t_wd();
    t_fifo();
    t_ce();
    wrap_up();
  end

  // hang guard, about 5000 cycles
  initial begin
    #20000;
    err_count++;
    $display("Error at %0t ns: run did not finish", $time);
    wrap_up();
  end
endmodule
`default_nettype wire

// ==== verification/coupler_model.sv ====
// bus coupler model: offers image words and takes the replies
`timescale 1ns/10ps
`default_nettype none
module coupler_model (
  input  wire logic        i_clk,
  input  wire logic        i_img_ready,
  input  wire logic        i_reply_valid,
  input  wire logic [7:0]  i_img_status,
  input  wire logic [15:0] i_img_word,
  output logic             o_img_valid = 1'b0,
  output logic             o_img_chan = 1'b0,
  output logic [7:0]       o_img_ctrl = 8'h00,
  output logic [15:0]      o_img_word = 16'h0000,
  output logic             o_reply_ready = 1'b0
);
  int slow = 0; // stall cycles before a reply is taken

  // offer one word (channel, control byte, data) and hold it until taken
  task automatic put(input logic ch, input logic [7:0] c, input logic [15:0] w);
    int n = 0;
    o_img_valid <= 1'b1;
    o_img_chan  <= ch;
    o_img_ctrl  <= c;
    o_img_word  <= w;
    @(posedge i_clk);
    while (!i_img_ready && n < 100) begin
      @(posedge i_clk);
      n++;
    end
    o_img_valid <= 1'b0;
    o_img_ctrl  <= ~c; // released lines must not keep the last value
    o_img_word  <= ~w;
  endtask

  // take one reply, possibly after a stall
  task automatic get(output logic [7:0] st, output logic [15:0] w);
    int n = 0;
    repeat (slow) @(posedge i_clk);
    o_reply_ready <= 1'b1;
    @(posedge i_clk);
    while (!i_reply_valid && n < 100) begin
      @(posedge i_clk);
      n++;
    end
    st = i_img_status;
    w  = i_img_word;
    o_reply_ready <= 1'b0;
  endtask

  // one complete request and reply
  task automatic xfer(input logic ch, input logic [7:0] c, input logic [15:0] w,
                      output logic [7:0] st, output logic [15:0] rw);
    put(ch, c, w);
    get(st, rw);
  endtask
endmodule
`default_nettype wire
